// ===== scmc_cfg.svh
// Purpose: constants for the serial configuration and mode control block
// Assumes: core_clk at 100 MHz
// Notes:   definitions only
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH
`define SCMC_WORD_W      16
`define SCMC_DATA_W      14
`define SCMC_ADDR_W      2
`define SCMC_ADDR_PLL    2'h0
`define SCMC_ADDR_CHAN   2'h1
`define SCMC_ADDR_TEST   2'h2
// the one address that selects no register
`define SCMC_ADDR_NONE   2'h3
// bus idle levels {strobe, data, clk}: strobe high, clock low
`define SCMC_BUS_IDLE    3'h4
// filter calibration after leaving standby, in core_clk cycles (256 us)
`define SCMC_CAL_CYCLES  25600
`define SCMC_DATA_RST    14'h0000
`define SCMC_WORD_RST    16'h0000
// second intermediate frequency in kHz, the shift applied between rx and tx
`define SCMC_IF2_KHZ     1024
`define SCMC_STEP_KHZ    1024
`define SCMC_LO_OFFSET   14'h0001
`endif

// ===== scmc_pkg.sv
// Purpose: types for the serial configuration and mode control block
// Assumes: scmc_cfg.svh provides widths
// Notes:   mode enum is one-hot
`default_nettype none
`include "scmc_cfg.svh"
package scmc_pkg;
  typedef enum logic [2:0] {
    SCMC_STANDBY  = 3'b001,
    SCMC_RECEIVE  = 3'b010,
    SCMC_TRANSMIT = 3'b100
  } scmc_mode_e;
  typedef struct packed {
    logic [`SCMC_DATA_W-1:0] pll_cfg;
    logic [`SCMC_DATA_W-1:0] chan;
    logic [`SCMC_DATA_W-1:0] test_cfg;
  } scmc_regs_s;
  typedef struct packed {
    logic strobe;
    logic data;
    logic clk;
  } scmc_bus_s;
endpackage : scmc_pkg
`default_nettype wire

// ===== scmc_top.sv
// Purpose: three-wire write-only configuration bus and mode pin decode
// Assumes: bus pins asynchronous to core_clk; bus clock period >= 50 ns
// Notes:   all pins pass two flops; edges found on the synchronised copies
//
// Contract
// - on a rising strobe the shift register is committed to the register.
// - with the strobe high, data and clock are ignored and the shifter holds.
// - data is shifted in on each rising bus clock while the strobe is low.
// - chip-active low means standby regardless of receive-select.
// - chip-active high selects receive if receive-select is 1, else transmit.
// - a write to register 1 retunes the channel at any time.
// - the local oscillator shifts by the second IF between rx and tx.
// - each word is a 14-bit data field then a 2-bit address field.
// - configuration registers are write-only with no read path.
`default_nettype none
`include "scmc_cfg.svh"
module scmc_top
  import scmc_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    cfg_strobe,
  input  wire logic                    cfg_data,
  input  wire logic                    cfg_clk,
  input  wire logic                    chip_active_select,
  input  wire logic                    receive_select,
  output var  scmc_regs_s              cfg_regs,
  output var  scmc_mode_e              mode,
  output var  logic [`SCMC_DATA_W-1:0] lo_word,
  output var  logic                    rx_power,
  output var  logic                    tx_power
);

////////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; first stage feeds only the second
  scmc_bus_s  bus_m_q;
  scmc_bus_s  bus_s_q;
  scmc_bus_s  bus_p_q;
  logic [1:0] pin_m_q;
  logic [1:0] pin_s_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // reset to the idle levels, so a high strobe is no false rise
      bus_m_q <= `SCMC_BUS_IDLE;
      bus_s_q <= `SCMC_BUS_IDLE;
      bus_p_q <= `SCMC_BUS_IDLE;
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      bus_m_q <= '{strobe: cfg_strobe, data: cfg_data, clk: cfg_clk};
      bus_s_q <= bus_m_q;
      bus_p_q <= bus_s_q;
      pin_m_q <= {chip_active_select, receive_select};
      pin_s_q <= pin_m_q;
    end
  end

  logic clk_rise;
  logic strobe_rise;
  assign clk_rise    = bus_s_q.clk & ~bus_p_q.clk;
  assign strobe_rise = bus_s_q.strobe & ~bus_p_q.strobe;

////////////////////////////////////////////////////////////////////////////////
  // shifter, msb arrives first so it ends at the top bit
  logic [`SCMC_WORD_W-1:0] shift_q;
  logic [`SCMC_WORD_W-1:0] shift_d;

  always_comb begin
    shift_d = shift_q;
    if (clk_rise && !bus_s_q.strobe) begin
      shift_d = {shift_q[`SCMC_WORD_W-2:0], bus_s_q.data};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= `SCMC_WORD_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // commit on strobe rise; no read path exists by design
  logic [`SCMC_DATA_W-1:0] word_data;
  logic [`SCMC_ADDR_W-1:0] word_addr;
  assign word_data = shift_q[`SCMC_WORD_W-1:`SCMC_ADDR_W];
  assign word_addr = shift_q[`SCMC_ADDR_W-1:0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_regs <= '{`SCMC_DATA_RST, `SCMC_DATA_RST, `SCMC_DATA_RST};
    end else if (strobe_rise) begin
      case (word_addr)
        `SCMC_ADDR_PLL:  cfg_regs.pll_cfg  <= word_data;
        `SCMC_ADDR_CHAN: cfg_regs.chan     <= word_data;
        `SCMC_ADDR_TEST: cfg_regs.test_cfg <= word_data;
        default: ;
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // mode decode from synchronised pins
  scmc_mode_e mode_d;
  always_comb begin
    case (pin_s_q)
      2'b00, 2'b01: mode_d = SCMC_STANDBY;
      2'b11:        mode_d = SCMC_RECEIVE;
      2'b10:        mode_d = SCMC_TRANSMIT;
      default:      mode_d = SCMC_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode     <= SCMC_STANDBY;
      rx_power <= 1'b0;
      tx_power <= 1'b0;
    end else begin
      mode     <= mode_d;
      rx_power <= (mode_d == SCMC_RECEIVE);
      tx_power <= (mode_d == SCMC_TRANSMIT);
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // lo word in 1.024 MHz steps; receive sits one second-if step below
  // the channel, so the lo moves by exactly one step at each rx/tx swap
  logic [`SCMC_DATA_W-1:0] chan_nx;
  always_comb begin
    chan_nx = (mode_d == SCMC_RECEIVE && mode_d != SCMC_STANDBY) ?
              cfg_regs.chan - `SCMC_LO_OFFSET : cfg_regs.chan;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_word <= `SCMC_DATA_RST;
    end else begin
      lo_word <= chan_nx;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_shift_hold;
    @(posedge core_clk) disable iff (sys_rst)
    bus_s_q.strobe |=> (shift_q == $past(shift_q));
  endproperty
  a_shift_hold: assert property (p_shift_hold)
    else $error("shifter moved while strobe high");

  property p_shift_in;
    @(posedge core_clk) disable iff (sys_rst)
    (clk_rise && !bus_s_q.strobe) |=>
      (shift_q[0] == $past(bus_s_q.data));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("bus bit not shifted in");

  property p_chan_commit;
    @(posedge core_clk) disable iff (sys_rst)
    (strobe_rise && word_addr == `SCMC_ADDR_CHAN) |=>
      (cfg_regs.chan == $past(word_data));
  endproperty
  a_chan_commit: assert property (p_chan_commit)
    else $error("channel register not loaded");

  property p_commit;
    @(posedge core_clk) disable iff (sys_rst)
    (strobe_rise && word_addr == `SCMC_ADDR_PLL) |=>
      (cfg_regs.pll_cfg == $past(word_data));
  endproperty
  a_commit: assert property (p_commit)
    else $error("pll register not loaded");

  property p_discard;
    @(posedge core_clk) disable iff (sys_rst)
    (strobe_rise && word_addr == `SCMC_ADDR_NONE) |=> $stable(cfg_regs);
  endproperty
  a_discard: assert property (p_discard)
    else $error("undefined address changed a register");

  property p_no_strobe;
    @(posedge core_clk) disable iff (sys_rst)
    !strobe_rise |=> $stable(cfg_regs);
  endproperty
  a_no_strobe: assert property (p_no_strobe)
    else $error("register changed without strobe");

  property p_standby;
    @(posedge core_clk) disable iff (sys_rst)
    !pin_s_q[1] |=> (mode == SCMC_STANDBY && !rx_power && !tx_power);
  endproperty
  a_standby: assert property (p_standby)
    else $error("not in standby with chip inactive");

  property p_active;
    @(posedge core_clk) disable iff (sys_rst)
    pin_s_q[1] |=>
      (mode == ($past(pin_s_q[0]) ? SCMC_RECEIVE : SCMC_TRANSMIT));
  endproperty
  a_active: assert property (p_active)
    else $error("wrong active mode");

  property p_lo_shift;
    @(posedge core_clk) disable iff (sys_rst)
    (mode == SCMC_RECEIVE) |->
      (lo_word == $past(cfg_regs.chan) - `SCMC_LO_OFFSET);
  endproperty
  a_lo_shift: assert property (p_lo_shift)
    else $error("lo not offset in receive");

  // outside receive the lo sits on the channel itself
  property p_lo_tx;
    @(posedge core_clk) disable iff (sys_rst)
    (mode != SCMC_RECEIVE) |-> (lo_word == $past(cfg_regs.chan));
  endproperty
  a_lo_tx: assert property (p_lo_tx)
    else $error("lo not on channel outside receive");

  c_rx: cover property (@(posedge core_clk) mode == SCMC_RECEIVE);
  c_tx: cover property (@(posedge core_clk)
    mode == SCMC_RECEIVE ##[1:300] mode == SCMC_TRANSMIT);
  c_wr: cover property (@(posedge core_clk)
    strobe_rise && word_addr == `SCMC_ADDR_CHAN);
  c_discard: cover property (@(posedge core_clk)
    strobe_rise && word_addr == `SCMC_ADDR_NONE);

endmodule : scmc_top
`default_nettype wire

// ===== scmc_host.sv
// Purpose: host model driving the three-wire configuration bus
// Assumes: bus clock period 125 ns, clock stands still between frames except while junk runs
// Notes:   data line inverted as the strobe rises at the end of every frame
`default_nettype none
module scmc_host (
  output var logic cfg_strobe,
  output var logic cfg_data,
  output var logic cfg_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: strobe high, clock low
  initial begin
    cfg_strobe = 1'b1;
    cfg_data   = 1'b0;
    cfg_clk    = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // frame of n bits, msb first; n of 0 sends no bits, pulses the strobe and flips the data line
  task automatic send(input logic [15:0] w, input int n);
    cfg_strobe = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      cfg_data = w[i];
      #62.5 cfg_clk = 1'b1;
      #62.5 cfg_clk = 1'b0;
    end
    #62.5 cfg_strobe = 1'b1;
    cfg_data = ~cfg_data;
    #100;
  endtask : send
  // clock and data toggled while the strobe is high, must be ignored
  task automatic junk();
    for (int i = 0; i < 16; i++) begin
      cfg_data = ~cfg_data;
      #62.5 cfg_clk = 1'b1;
      #62.5 cfg_clk = 1'b0;
    end
  endtask : junk
endmodule : scmc_host
`default_nettype wire

// ===== test_serial_config_mode_control.sv
// Purpose: self-checking bench for the configuration bus and mode decode
// Assumes: host model drives the bus pins
// Notes:   expectations kept in a local copy of the register set
`default_nettype none
`include "scmc_cfg.svh"
module test_serial_config_mode_control
  import scmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       chip_active_select = 1'b0;
  logic       receive_select     = 1'b0;
  wire logic  cfg_strobe, cfg_data, cfg_clk;
  scmc_regs_s cfg_regs, exp_q;
  scmc_mode_e mode, em;
  logic [13:0] lo_word;
  logic       rx_power, tx_power;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         cycles     = 0;
  scmc_top DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .cfg_strobe(cfg_strobe), .cfg_data(cfg_data), .cfg_clk(cfg_clk),
    .chip_active_select(chip_active_select),
    .receive_select(receive_select), .cfg_regs(cfg_regs), .mode(mode),
    .lo_word(lo_word), .rx_power(rx_power), .tx_power(tx_power));
  scmc_host host (.cfg_strobe(cfg_strobe), .cfg_data(cfg_data),
    .cfg_clk(cfg_clk));
  always #5 core_clk = ~core_clk;
  // hang guard: run needs about 28000 cycles, most of it calibration
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [41:0] seen, input logic [41:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic settle();
    repeat (8) @(negedge core_clk);
  endtask : settle
  // one word; the expected copy changes only for defined addresses
  task automatic wr(input logic [1:0] a, input logic [13:0] d);
    host.send({d, a}, 16);
    settle();
    case (a)
      `SCMC_ADDR_PLL:  exp_q.pll_cfg  = d;
      `SCMC_ADDR_CHAN: exp_q.chan     = d;
      `SCMC_ADDR_TEST: exp_q.test_cfg = d;
      default: ;
    endcase
    check(42'(cfg_regs), 42'(exp_q));
  endtask : wr
  task automatic t_write();
    wr(2'h0, 14'h2A5C);
    wr(2'h1, 14'h1F3E);
    wr(2'h2, 14'h0001);
    wr(`SCMC_ADDR_NONE, 14'h3FFF);
    $display("t_write done");
  endtask : t_write
  // junk with strobe high, then a bare strobe pulse recommits the shifter
  task automatic t_hold();
    wr(2'h1, 14'h0155);
    host.junk();
    host.send(16'h0000, 0);
    settle();
    check(42'(cfg_regs), 42'(exp_q));
    $display("t_hold done");
  endtask : t_hold
  // pins change at a falling edge; settle covers the three-flop path
  task automatic set_mode(input logic ca, input logic rs);
    chip_active_select = ca;
    receive_select     = rs;
    settle();
    em = !ca ? SCMC_STANDBY : (rs ? SCMC_RECEIVE : SCMC_TRANSMIT);
    check(42'(mode), 42'(em));
    check(42'({rx_power, tx_power}),
          42'({em == SCMC_RECEIVE, em == SCMC_TRANSMIT}));
    check(42'(lo_word), 42'(em == SCMC_RECEIVE ?
          exp_q.chan - `SCMC_LO_OFFSET : exp_q.chan));
  endtask : set_mode
  // standby first, receive while filters calibrate, then swaps and retunes
  task automatic t_modes();
    set_mode(1'b0, 1'b0);
    set_mode(1'b0, 1'b1);
    set_mode(1'b1, 1'b1);
    repeat (`SCMC_CAL_CYCLES) @(negedge core_clk);
    set_mode(1'b1, 1'b0);
    wr(2'h1, 14'h0300);
    set_mode(1'b1, 1'b0);
    set_mode(1'b1, 1'b1);
    wr(2'h1, 14'h1234);
    set_mode(1'b1, 1'b1);
    set_mode(1'b0, 1'b1);
    $display("t_modes done");
  endtask : t_modes
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // reset for 8 cycles, then the scenarios
  initial begin
    exp_q = '0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    settle();
    check(42'(cfg_regs), 42'(exp_q));
    check(42'(mode), 42'(SCMC_STANDBY));
    t_write();
    t_hold();
    t_modes();
    summarize();
  end
endmodule : test_serial_config_mode_control
`default_nettype wire
